// ---- inc/slfr_map.svh ----
/*
  Constants of the status indicator and default-restore block: register
  offsets, field positions, reset values and timing figures.
  Assumes a 20 MHz module clock and a 32-bit APB register bus.
*/
`ifndef SLFR_MAP_SVH
`define SLFR_MAP_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define SLFR_OFS_CTRL      8'h00
`define SLFR_OFS_STATUS    8'h04
`define SLFR_OFS_INT_STAT  8'h08
`define SLFR_OFS_INT_MASK  8'h0C

// ------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------
`define SLFR_CTRL_CMD_BIT   0
`define SLFR_CTRL_RST       1'h0
`define SLFR_ST_LINK_BIT    0
`define SLFR_ST_CMD_BIT     1
`define SLFR_ST_BLINK_BIT   2
`define SLFR_ST_RESTORE_BIT 3
`define SLFR_ST_WATCH_BIT   4
`define SLFR_INT_RESTORE    0
`define SLFR_INT_ABANDON    1
`define SLFR_INT_LINK_UP    2
`define SLFR_INT_LINK_DOWN  3
`define SLFR_INT_W          4
`define SLFR_MASK_RST       4'h0

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define SLFR_CLK_PERIOD_NS  50
`define SLFR_TICK_MS        1
`define SLFR_TICK_CYC       (`SLFR_TICK_MS * 1000000 / `SLFR_CLK_PERIOD_NS)
`define SLFR_DISC_HZ        1
`define SLFR_CMD_HZ         10
`define SLFR_DISC_HALF_MS   (1000 / (2 * `SLFR_DISC_HZ))
`define SLFR_CMD_HALF_MS    (1000 / (2 * `SLFR_CMD_HZ))
`define SLFR_RISE_GAP_MS    1000
`define SLFR_GAP_TOL_MS     250
`define SLFR_STEP_LIMIT_MS  3000
`define SLFR_DEBOUNCE_MS    20

`endif

// ---- inc/slfr_pkg.sv ----
/*
  Types of the status indicator and default-restore block.
  Assumes slfr_map.svh supplies the numeric constants.
*/
package slfr_pkg;

  // ------------------------------------------------------------
  // Default-restore watcher states
  // ------------------------------------------------------------
  typedef enum logic [5:0] {
    SLFR_ARM   = 6'h01,
    SLFR_FALL1 = 6'h02,
    SLFR_RISE1 = 6'h04,
    SLFR_FALL2 = 6'h08,
    SLFR_RISE2 = 6'h10,
    SLFR_IDLE  = 6'h20
  } slfr_seq_t;

  // ------------------------------------------------------------
  // Indicator modes
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    SLFR_M_DISC = 3'h1,
    SLFR_M_CMD  = 3'h2,
    SLFR_M_LINK = 3'h4
  } slfr_mode_t;

endpackage

// ---- rtl/slfr_debounce.sv ----
/*
  Debounce filter for the factory-default input.
  Assumes the input is synchronous to clk_i and tick_i is a one-cycle
  pulse once per millisecond.
*/
`timescale 1ns/100ps
`include "slfr_map.svh"

module slfr_debounce
  import slfr_pkg::*;
#(
  parameter int unsigned STABLE_TICKS = `SLFR_DEBOUNCE_MS
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_ni,
  // Sampling
  input  wire logic tick_i,
  input  wire logic raw_i,
  // Filtered level
  output logic      level_o,
  output logic      settled_o
);

  if (STABLE_TICKS < 1 || STABLE_TICKS > 255) begin : g_chk
    $error("slfr_debounce: STABLE_TICKS out of range");
  end

  logic       cand_q, cand_d;
  logic [7:0] cnt_q, cnt_d;
  logic       level_d, settled_d;

  // ------------------------------------------------------------
  // Filter
  // ------------------------------------------------------------
  always_comb begin
    cand_d    = cand_q;
    cnt_d     = cnt_q;
    level_d   = level_o;
    settled_d = settled_o;
    if (raw_i != cand_q) begin
      // Any glitch restarts the stability count
      cand_d = raw_i;
      cnt_d  = 8'h00;
    end else if (tick_i) begin
      if (cnt_q == 8'(STABLE_TICKS - 1)) begin
        level_d   = cand_q;
        settled_d = 1'b1;
      end else begin
        cnt_d = cnt_q + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_ni) begin
    if (!rst_ni) begin
      cand_q    <= 1'b0;
      cnt_q     <= 8'h00;
      level_o   <= 1'b0;
      settled_o <= 1'b0;
    end else begin
      cand_q    <= cand_d;
      cnt_q     <= cnt_d;
      level_o   <= level_d;
      settled_o <= settled_d;
    end
  end

endmodule

// ---- rtl/slfr_top.sv ----
/*
  Status indicator and default-restore supervisor with an APB register
  file and a level interrupt.
  Assumes all inputs synchronous to clk_i (20 MHz) and resetn_i driven
  low by the host for device reset.
*/
// The address map and the APB slave port are this design's own decisions.
// Notes on behaviour
// (RULE1) Host: pin high at power-up, toggle twice
// (RULE2) Full sequence seen: restore every factory default
// (RULE3) Discoverable, no link: blink at 1 Hz
// (RULE4) Command state: blink at 10 Hz
// (RULE5) Linked: blink output held steadily high
// (RULE6) Link output follows connection state directly
// (RULE7) No link: link output low in any state
// (RULE8) Reset active low; release marks power-up
// (RULE9) Debounce pin; rise gap within tolerance window
`timescale 1ns/100ps
`include "slfr_map.svh"

module slfr_top
  import slfr_pkg::*;
#(
  parameter int unsigned TICK_CYC   = `SLFR_TICK_CYC,
  parameter int unsigned DISC_HALF  = `SLFR_DISC_HALF_MS,
  parameter int unsigned CMD_HALF   = `SLFR_CMD_HALF_MS,
  parameter int unsigned GAP_MS     = `SLFR_RISE_GAP_MS,
  parameter int unsigned GAP_TOL    = `SLFR_GAP_TOL_MS,
  parameter int unsigned STEP_LIMIT = `SLFR_STEP_LIMIT_MS,
  parameter int unsigned DEB_MS     = `SLFR_DEBOUNCE_MS
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic             pready_o,
  output logic [31:0]      prdata_o,
  output logic             pslverr_o,
  // Device pins
  input  wire logic        factory_default_pin_i,
  output logic             status_blink_pin_o,
  output logic             link_state_pin_o,
  // Core side
  input  wire logic        link_up_i,
  output logic             restore_defaults_o,
  output logic             irq_o
);

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  if (TICK_CYC < 2 || TICK_CYC > 1048575) begin : g_chk_tick
    $error("slfr_top: TICK_CYC out of range");
  end
  if (DISC_HALF < 1 || CMD_HALF < 1 || DISC_HALF > 8191
      || CMD_HALF > 8191) begin : g_chk_blink
    $error("slfr_top: blink half periods out of range");
  end
  if (GAP_TOL >= GAP_MS || GAP_MS + GAP_TOL >= STEP_LIMIT
      || STEP_LIMIT > 8191) begin : g_chk_gap
    $error("slfr_top: restore timing out of range");
  end

  localparam logic [12:0] GAP_MIN = 13'(GAP_MS - GAP_TOL);
  localparam logic [12:0] GAP_MAX = 13'(GAP_MS + GAP_TOL);
  localparam logic [12:0] STEP_MAX = 13'(STEP_LIMIT);

  function automatic logic [31:0] widen(input logic [`SLFR_INT_W-1:0] v);
    widen = {28'h0000000, v};
  endfunction

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic [1:0] rsync_q;
  logic       rst_n;

  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rsync_q <= 2'h0;
    end else begin
      rsync_q <= {rsync_q[0], 1'b1};
    end
  end
  assign rst_n = rsync_q[1];

  // ------------------------------------------------------------
  // Millisecond timebase
  // ------------------------------------------------------------
  logic [19:0] pre_q, pre_d;
  logic        tick_q, tick_d;

  always_comb begin
    pre_d  = pre_q + 20'h00001;
    tick_d = 1'b0;
    if (pre_q == 20'(TICK_CYC - 1)) begin
      pre_d  = 20'h00000;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pre_q  <= 20'h00000;
      tick_q <= 1'b0;
    end else begin
      pre_q  <= pre_d;
      tick_q <= tick_d;
    end
  end

  // ------------------------------------------------------------
  // Default-restore watcher
  // ------------------------------------------------------------
  logic        pin_lvl, pin_ok, pin_prev_q;
  logic        rise, fall;
  slfr_seq_t   seq_q, seq_d;
  logic [12:0] ms_q, ms_d;
  logic        restore_d, abandon_ev;

  slfr_debounce #(
    .STABLE_TICKS (DEB_MS)
  ) u_deb (
    .clk_i     (clk_i),
    .rst_ni    (rst_n),
    .tick_i    (tick_q),
    .raw_i     (factory_default_pin_i),
    .level_o   (pin_lvl),
    .settled_o (pin_ok)
  ); // see (RULE9)

  assign rise = pin_lvl & ~pin_prev_q;
  assign fall = ~pin_lvl & pin_prev_q;

  always_comb begin
    seq_d      = seq_q;
    ms_d       = (tick_q && ms_q != 13'h1FFF) ? ms_q + 13'h0001 : ms_q;
    restore_d  = 1'b0;
    abandon_ev = 1'b0;
    unique case (seq_q)
      SLFR_ARM: begin
        // First settled level after reset release is the power-up level
        ms_d = 13'h0000;
        if (pin_ok) begin
          seq_d = pin_lvl ? SLFR_FALL1 : SLFR_IDLE; // see (RULE8)
        end
      end
      SLFR_FALL1: begin
        if (fall) begin
          seq_d = SLFR_RISE1;
          ms_d  = 13'h0000;
        end else if (ms_q >= STEP_MAX) begin
          // Pin simply strapped high: no restore, not an error
          seq_d = SLFR_IDLE;
        end
      end
      SLFR_RISE1: begin
        if (rise) begin
          seq_d = SLFR_FALL2;
          ms_d  = 13'h0000;
        end else if (ms_q >= STEP_MAX) begin
          seq_d      = SLFR_IDLE;
          abandon_ev = 1'b1;
        end
      end
      SLFR_FALL2: begin
        // Interval keeps running from the first rise
        if (ms_q > GAP_MAX) begin
          seq_d      = SLFR_IDLE;
          abandon_ev = 1'b1; // see (RULE9)
        end else if (fall) begin
          seq_d = SLFR_RISE2;
        end
      end
      SLFR_RISE2: begin
        if (rise && ms_q >= GAP_MIN && ms_q <= GAP_MAX) begin
          seq_d     = SLFR_IDLE;
          restore_d = 1'b1; // see (RULE1) (RULE2) (RULE9)
        end else if (rise || ms_q > GAP_MAX) begin
          seq_d      = SLFR_IDLE;
          abandon_ev = 1'b1; // see (RULE9)
        end
      end
      SLFR_IDLE: begin
        ms_d = 13'h0000;
      end
      default: begin
        seq_d = SLFR_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      seq_q              <= SLFR_ARM;
      ms_q               <= 13'h0000;
      pin_prev_q         <= 1'b0;
      restore_defaults_o <= 1'b0;
    end else begin
      seq_q              <= seq_d;
      ms_q               <= ms_d;
      pin_prev_q         <= pin_lvl;
      restore_defaults_o <= restore_d;
    end
  end

  // ------------------------------------------------------------
  // Indicator outputs
  // ------------------------------------------------------------
  logic        cmd_q, cmd_d;
  slfr_mode_t  mode, mode_q;
  logic [12:0] bl_q, bl_d;
  logic        blink_d;
  logic        link_prev_q;

  always_comb begin
    if (link_up_i) begin
      mode = SLFR_M_LINK;
    end else if (cmd_q) begin
      mode = SLFR_M_CMD;
    end else begin
      mode = SLFR_M_DISC;
    end
  end

  always_comb begin
    bl_d    = (tick_q) ? bl_q + 13'h0001 : bl_q;
    blink_d = status_blink_pin_o;
    unique case (mode)
      SLFR_M_LINK: begin
        bl_d    = 13'h0000;
        blink_d = 1'b1; // see (RULE5)
      end
      SLFR_M_CMD: begin
        if (tick_q && bl_q == 13'(CMD_HALF - 1)) begin
          bl_d    = 13'h0000;
          blink_d = ~status_blink_pin_o; // see (RULE4)
        end
      end
      SLFR_M_DISC: begin
        if (tick_q && bl_q == 13'(DISC_HALF - 1)) begin
          bl_d    = 13'h0000;
          blink_d = ~status_blink_pin_o; // see (RULE3)
        end
      end
    endcase
    // Restart the phase on a mode change so the new rate shows at once
    if (mode != mode_q) begin
      bl_d = 13'h0000;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bl_q               <= 13'h0000;
      mode_q             <= SLFR_M_DISC;
      status_blink_pin_o <= 1'b0;
      link_state_pin_o   <= 1'b0;
      link_prev_q        <= 1'b0;
    end else begin
      bl_q               <= bl_d;
      mode_q             <= mode;
      status_blink_pin_o <= blink_d;
      link_state_pin_o   <= link_up_i; // see (RULE6) (RULE7)
      link_prev_q        <= link_up_i;
    end
  end

  // ------------------------------------------------------------
  // APB register file and interrupt
  // ------------------------------------------------------------
  logic                  setup, access;
  logic                  pready_d, pslverr_d;
  logic [31:0]           prdata_d;
  logic [`SLFR_INT_W-1:0] ist_q, ist_d, imask_q, imask_d, iset;
  logic                  irq_d, restored_q, restored_d, hit;

  assign setup  = psel_i & ~penable_i;
  assign access = psel_i & penable_i & pready_o;

  always_comb begin
    iset = '0;
    iset[`SLFR_INT_RESTORE]   = restore_d;
    iset[`SLFR_INT_ABANDON]   = abandon_ev;
    iset[`SLFR_INT_LINK_UP]   = link_up_i & ~link_prev_q;
    iset[`SLFR_INT_LINK_DOWN] = ~link_up_i & link_prev_q;
  end

  always_comb begin
    pready_d   = setup;
    pslverr_d  = 1'b0;
    prdata_d   = 32'h00000000;
    hit        = 1'b1;
    cmd_d      = cmd_q;
    imask_d    = imask_q;
    ist_d      = ist_q;
    restored_d = restored_q | restore_d;
    unique case (paddr_i)
      `SLFR_OFS_CTRL: begin
        prdata_d[`SLFR_CTRL_CMD_BIT] = cmd_q;
      end
      `SLFR_OFS_STATUS: begin
        prdata_d[`SLFR_ST_LINK_BIT]    = link_state_pin_o;
        prdata_d[`SLFR_ST_CMD_BIT]     = cmd_q;
        prdata_d[`SLFR_ST_BLINK_BIT]   = status_blink_pin_o;
        prdata_d[`SLFR_ST_RESTORE_BIT] = restored_q;
        prdata_d[`SLFR_ST_WATCH_BIT]   = (seq_q != SLFR_IDLE);
      end
      `SLFR_OFS_INT_STAT: begin
        prdata_d = widen(ist_q);
      end
      `SLFR_OFS_INT_MASK: begin
        prdata_d = widen(imask_q);
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    if (setup) begin
      pslverr_d = ~hit;
      if (!hit) begin
        prdata_d = 32'h00000000;
      end
    end else begin
      prdata_d = prdata_o;
    end
    if (access && pwrite_i && hit) begin
      unique case (paddr_i)
        `SLFR_OFS_CTRL: cmd_d = pwdata_i[`SLFR_CTRL_CMD_BIT];
        `SLFR_OFS_INT_MASK: imask_d = pwdata_i[`SLFR_INT_W-1:0];
        default: begin
        end
      endcase
    end
    // Read clears status; a same-cycle event still lands
    if (access && !pwrite_i && paddr_i == `SLFR_OFS_INT_STAT) begin
      ist_d = '0;
    end
    ist_d = ist_d | iset;
    // Stored settings fall back to factory values
    if (restore_d) begin
      cmd_d   = `SLFR_CTRL_RST; // see (RULE2)
      imask_d = `SLFR_MASK_RST;
    end
    irq_d = |(ist_d & imask_d);
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pready_o   <= 1'b0;
      pslverr_o  <= 1'b0;
      prdata_o   <= 32'h00000000;
      cmd_q      <= `SLFR_CTRL_RST;
      imask_q    <= `SLFR_MASK_RST;
      ist_q      <= '0;
      restored_q <= 1'b0;
      irq_o      <= 1'b0;
    end else begin
      pready_o   <= pready_d;
      pslverr_o  <= pslverr_d;
      prdata_o   <= prdata_d;
      cmd_q      <= cmd_d;
      imask_q    <= imask_d;
      ist_q      <= ist_d;
      restored_q <= restored_d;
      irq_o      <= irq_d;
    end
  end

endmodule

// ---- sim/slfr_host_model.sv ----
/*
  Model of the switch or host on the factory-default pin.
  Assumes the bench calls its tasks just after a rising clock edge.
*/
`timescale 1ns/100ps
module slfr_host_model #(
  parameter int unsigned TICK_CYC = 20
) (
  // Clock
  input  wire logic clk_i,
  // Pin
  output logic      factory_default_pin_o
);
  initial factory_default_pin_o = 1'b0;
  task automatic hold(input logic v, input int unsigned ticks);
    factory_default_pin_o <= v;
    repeat (ticks * TICK_CYC) @(posedge clk_i);
  endtask
  // High from power-up, then two low-high toggles, rises gap ticks apart
  task automatic restore_seq(input int unsigned gap);
    hold(1'b1, 10);
    hold(1'b0, 10);
    hold(1'b1, gap - 10);
    hold(1'b0, 10);
    hold(1'b1, 10);
  endtask
endmodule

// ---- sim/slfr_top_properties.sv ----
/*
  Checker of the pin and bus timing of slfr_top.
  Assumes it is bound to slfr_top and given its timing parameters.
*/
`timescale 1ns/100ps
module slfr_top_checker #(
  parameter int unsigned TICK_CYC  = 20,
  parameter int unsigned DISC_HALF = 500,
  parameter int unsigned CMD_HALF  = 50
) (
  // Clock, reset and bus
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic psel_i,
  input  wire logic penable_i,
  input  wire logic pwrite_i,
  input  wire logic pready_o,
  input  wire logic pslverr_o,
  // Pins and core side
  input  wire logic link_up_i,
  input  wire logic status_blink_pin_o,
  input  wire logic link_state_pin_o,
  input  wire logic restore_defaults_o
);
  localparam int unsigned MAXH = (DISC_HALF + 2) * TICK_CYC;
  localparam int unsigned MINH = (CMD_HALF - 1) * TICK_CYC;
  // ------------------------------------------------------------
  // Cycles since reset and since the last blink edge, link edge, write or restore
  // ------------------------------------------------------------
  logic [2:0]  up_q;
  logic [31:0] gap_q;
  logic        blink_q, link_q, done_q, live, moved, retime, timed_q;
  assign live   = (up_q == 3'h7);
  assign moved  = (status_blink_pin_o != blink_q);
  // A write or a restore may restart the blink phase, so both re-time it
  assign retime = (link_up_i != link_q) || restore_defaults_o ||
                  (psel_i && pwrite_i);
  // Only a half period bounded by two blink edges is judged for speed
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      up_q    <= 3'h0;
      gap_q   <= 32'h0;
      blink_q <= 1'b0;
      link_q  <= 1'b0;
      done_q  <= 1'b0;
      timed_q <= 1'b0;
    end else begin
      up_q    <= live ? up_q : up_q + 3'h1;
      gap_q   <= (moved || retime) ? 32'h0 : gap_q + 32'h1;
      timed_q <= retime ? 1'b0 : (moved | timed_q);
      blink_q <= status_blink_pin_o;
      link_q  <= link_up_i;
      done_q  <= done_q | restore_defaults_o;
    end
  end
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);
  AST_LINK_FOLLOW: assert property (
    live |-> link_state_pin_o == $past(link_up_i))
    else $error("link pin not one clock behind link");
  AST_NO_LINK_LOW: assert property (
    live && !link_up_i |=> !link_state_pin_o)
    else $error("link pin high without link");
  AST_LINK_STEADY: assert property (
    live && link_up_i |=> status_blink_pin_o)
    else $error("blink pin not high while linked");
  AST_BLINK_SLOW: assert property (
    live && !link_up_i |-> gap_q <= MAXH)
    else $error("blink pin stopped toggling");
  AST_BLINK_FAST: assert property (
    live && moved && timed_q && !link_up_i |-> gap_q >= MINH)
    else $error("blink pin toggled too fast");
  AST_RESTORE_ONCE: assert property (
    restore_defaults_o |-> !done_q ##1 !restore_defaults_o)
    else $error("restore pulse repeated");
  AST_READY_ZERO_WAIT: assert property (
    psel_i && !penable_i ##1 psel_i && penable_i |-> pready_o)
    else $error("no ready in first access cycle");
  AST_ERR_WITH_READY: assert property (
    pslverr_o |-> pready_o && $past(psel_i) && !$past(penable_i))
    else $error("error flag outside an access");
endmodule

bind slfr_top slfr_top_checker #(
  .TICK_CYC(TICK_CYC), .DISC_HALF(DISC_HALF), .CMD_HALF(CMD_HALF)
) slfr_top_checker_i (
  .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .link_up_i(link_up_i),
  .status_blink_pin_o(status_blink_pin_o),
  .link_state_pin_o(link_state_pin_o),
  .restore_defaults_o(restore_defaults_o)
);

// ---- sim/status_led_and_factory_reset_tb_top.sv ----
/*
  Self-checking bench of slfr_top with scaled-down timing.
  Assumes the checker is bound in and the host model drives the pin.
*/
`timescale 1ns/100ps
`include "slfr_map.svh"
module status_led_and_factory_reset_tb_top;
  localparam int unsigned TK = 20, DH = 50, CH = 5, GAP = 100, TOL = 25;
  logic        clk_i, resetn_i, psel_i, penable_i, pwrite_i, link_up_i;
  logic        pready_o, pslverr_o, factory_default_pin_i, irq_o;
  logic        status_blink_pin_o, link_state_pin_o, restore_defaults_o;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o;
  logic [32:0] exp_q[$];
  int          errors, n_tests, n_restore, r;
  int unsigned n;
  slfr_top #(.TICK_CYC(TK), .DISC_HALF(DH), .CMD_HALF(CH), .GAP_MS(GAP),
    .GAP_TOL(TOL), .STEP_LIMIT(300), .DEB_MS(2)) slfr_top_i (
    .clk_i(clk_i), .resetn_i(resetn_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .pready_o(pready_o), .prdata_o(prdata_o),
    .pslverr_o(pslverr_o), .factory_default_pin_i(factory_default_pin_i),
    .status_blink_pin_o(status_blink_pin_o),
    .link_state_pin_o(link_state_pin_o), .link_up_i(link_up_i),
    .restore_defaults_o(restore_defaults_o), .irq_o(irq_o));
  slfr_host_model #(.TICK_CYC(TK)) slfr_host_model_i (
    .clk_i(clk_i), .factory_default_pin_o(factory_default_pin_i));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [32:0] seen, exp);
    n_tests++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Outputs settle by the falling edge, so reads are judged there
  always @(negedge clk_i) begin
    if (pready_o === 1'b1 && pwrite_i === 1'b0) begin
      if (exp_q.size() == 0) chk("stray read", 33'h1, 33'h0);
      else chk("apb read", {pslverr_o, prdata_o}, exp_q.pop_front());
    end
    if (restore_defaults_o === 1'b1) n_restore++;
  end
  // ------------------------------------------------------------
  // Drivers
  // ------------------------------------------------------------
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int t;
    psel_i <= 1'b1;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    t = 0;
    do begin
      @(negedge clk_i);
      t++;
    end while (pready_o !== 1'b1 && t < 20);
    if (t >= 20) errors++;
    @(posedge clk_i);
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic do_reset(input logic lvl);
    resetn_i <= 1'b0;
    slfr_host_model_i.hold(lvl, 0);
    repeat (6) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (4) @(posedge clk_i);
  endtask
  // Cycles between two successive blink edges
  task automatic half(output int unsigned m);
    logic b;
    @(negedge clk_i);
    b = status_blink_pin_o;
    m = 0;
    while (status_blink_pin_o === b && m < 4000) begin
      @(negedge clk_i);
      m++;
    end
    b = status_blink_pin_o;
    m = 0;
    while (status_blink_pin_o === b && m < 4000) begin
      @(negedge clk_i);
      m++;
    end
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    {psel_i, penable_i, pwrite_i, link_up_i, resetn_i} = 5'h0;
    paddr_i = 8'h0;
    pwdata_i = 32'h0;
    {errors, n_tests, n_restore} = {32'h0, 32'h0, 32'h0};
    void'($urandom(85597));
    @(posedge clk_i);
    do_reset(1'b0);
    rd(`SLFR_OFS_CTRL, 33'h0);
    rd(`SLFR_OFS_INT_MASK, 33'h0);
    rd(8'h10, {1'b1, 32'h0});
    half(n);
    chk("disc half", (n + TK / 2) / TK, DH);
    apb(1'b1, `SLFR_OFS_CTRL, 32'h1);
    half(n);
    chk("cmd half", (n + TK / 2) / TK, CH);
    apb(1'b1, `SLFR_OFS_INT_MASK, 32'h4);
    link_up_i <= 1'b1;
    repeat (2 + $urandom % 40) @(posedge clk_i);
    @(negedge clk_i);
    chk("link pin up", link_state_pin_o, 33'h1);
    chk("blink held", status_blink_pin_o, 33'h1);
    chk("irq raised", irq_o, 33'h1);
    @(posedge clk_i);
    // Linked, command mode, blink steady, watcher idle: bits 2:0 only
    rd(`SLFR_OFS_STATUS, 33'h7);
    rd(`SLFR_OFS_INT_STAT, 33'h4);
    @(negedge clk_i);
    chk("irq cleared", irq_o, 33'h0);
    @(posedge clk_i);
    link_up_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk("irq masked", irq_o, 33'h0);
    chk("link pin cmd", link_state_pin_o, 33'h0);
    @(posedge clk_i);
    rd(`SLFR_OFS_INT_STAT, 33'h8);
    apb(1'b1, `SLFR_OFS_CTRL, 32'h0);
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    chk("link pin disc", link_state_pin_o, 33'h0);
    @(posedge clk_i);
    // Good gap then a gap past the tolerance, each after a fresh power-up
    for (int k = 0; k < 2; k++) begin
      do_reset(1'b1);
      apb(1'b1, `SLFR_OFS_CTRL, 32'h1);
      apb(1'b1, `SLFR_OFS_INT_MASK, 32'h3);
      r = n_restore;
      slfr_host_model_i.restore_seq(k == 0 ? GAP - 10 + $urandom_range(20)
                                           : GAP + 2 * TOL);
      repeat (20 * TK) @(posedge clk_i);
      @(negedge clk_i);
      chk("restore count", n_restore - r, (k == 0));
      chk("irq after seq", irq_o, (k == 1));
      @(posedge clk_i);
      rd(`SLFR_OFS_CTRL, (k == 0) ? 33'h0 : 33'h1);
      rd(`SLFR_OFS_INT_STAT, (k == 0) ? 33'h1 : 33'h2);
    end
    close_out();
  end
  initial begin
    #(50 * 60000);
    errors++;
    close_out();
  end
endmodule
